// >>> hdl/cdp_pkg.sv
// cdp_pkg: constants for the compare / dead-band / steering unit
// assumes a plain register port with 4-bit word index and 8-bit data
package cdp_pkg;
   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [3:0] REG_TMR_LO   = 4'h0;
   localparam logic [3:0] REG_TMR_HI   = 4'h1;
   localparam logic [3:0] REG_CMP_LO   = 4'h2;
   localparam logic [3:0] REG_CMP_HI   = 4'h3;
   localparam logic [3:0] REG_UNIT_CTL = 4'h4;
   localparam logic [3:0] REG_DEL      = 4'h5;
   localparam logic [3:0] REG_STEER    = 4'h6;
   localparam logic [3:0] REG_STATUS   = 4'h7;
   localparam logic [3:0] REG_CONFIG   = 4'h8;
   localparam logic [3:0] REG_DUTY     = 4'h9;
   // ------------------------------------------------------------
   // reset values and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [15:0] TMR_MAX     = 16'hffff;
   localparam logic [15:0] TMR_ZERO    = 16'h0000;
   localparam int          STS_TOVF    = 0;
   localparam int          STS_CMPF    = 1;
   localparam int          STS_SHDN    = 2;
   localparam int          CFG_TOIE    = 0;
   localparam int          CFG_TBSEL   = 1;   // 3-bit field 3:1
   localparam int          CFG_ADON    = 4;
   localparam int          CFG_UNIT2   = 5;
   localparam int          DEL_RSEN    = 7;
   // ------------------------------------------------------------
   // mode encodings of unit_mode_select
   // ------------------------------------------------------------
   typedef enum logic [3:0]
   {
      CDP_M_OFF    = 4'b0000,
      CDP_M_TOG    = 4'b0010,
      CDP_M_SETHI  = 4'b1000,
      CDP_M_SETLO  = 4'b1001,
      CDP_M_SWIRQ  = 4'b1010,
      CDP_M_TRIG   = 4'b1011
   } cdp_mode_t;
endpackage : cdp_pkg

// >>> hdl/cdp_unit.sv
// cdp_unit: compare unit, time-base timers, dead band and pulse steering
// assumes registers on a plain strobe port, shutdown input from a pin
//
// Behaviour
// - each 16-bit timer counts up and wraps to zero; the selected one latches the overflow flag
// - overflow interrupt raised only when its enable bit is set
// - trigger compare mode: match resets the selected timer
// - second unit's trigger starts a conversion only if converter enabled
// - timer write in same cycle as trigger reset wins
// - trigger reset zeroes count without setting overflow flag
// - match drives pin high, low, toggles or leaves it per mode
// - compare flag set in the same cycle the match acts on pin
// - writing zero to control register forces compare output low
// - software interrupt mode: match sets only the flag
// - per-unit select field chooses time base among timers one to eight
// - half-bridge: inactive-to-active edge delayed by dead band
// - dead band equals 7-bit count in instruction cycles
// - restart enable: shutdown status self-clears; else software clears it
// - single-output mode steers one waveform to any of four pins
// - steering mode: mode bits 1:0 set output polarity
// - shutdown in steering mode acts only on enabled pins
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module cdp_unit
   import cdp_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // register port
   input  wire logic [3:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic [7:0]             regRdData,
   // pins and events
   input  wire logic              shutdownPin,
   output logic                   compareOut,
   output logic [3:0]             pwmOutputPins,
   output logic                   timerOverflowIrq,
   output logic                   adcStart
);
   import cdp_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [15:0] timerCountPair_q [8];
   logic [15:0] timerCountPair_d [8];
   logic [15:0] compareValueReg_q, compareValueReg_d;
   logic [7:0]  unitControlReg_q, unitControlReg_d;
   logic [7:0]  deadBandCtl_q, deadBandCtl_d;
   logic [3:0]  steeringControlReg_q, steeringControlReg_d;
   logic [7:0]  config_q, config_d;
   logic [7:0]  duty_q, duty_d;
   logic [7:0]  pwmPhase_q, pwmPhase_d;
   logic        timerOvfFlag_q, timerOvfFlag_d;
   logic        compareIrqFlag_q, compareIrqFlag_d;
   logic        shutdownStatus_q, shutdownStatus_d;
   logic        compareOut_q, compareOut_d;
   logic [6:0]  dbCntA_q, dbCntA_d, dbCntB_q, dbCntB_d;
   logic [3:0]  pins_q, pins_d;
   logic [7:0]  rdData_q, rdData_d;
   logic        irq_q, irq_d, adc_q, adc_d;
   logic        shdnMeta_q, shdnSync_q;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   logic [2:0]  tbSel;
   logic [3:0]  mode;
   logic        match, trig, wrTmrLo, wrTmrHi, wrCtl;
   logic        pwmRaw, pwmMode, steerMode, halfBridge;
   logic [3:0]  rawPins;

   function automatic logic isWrite(input logic [3:0] a, input logic [3:0] r, input logic w);
      isWrite = w && (a == r);
   endfunction : isWrite

   assign tbSel     = config_q[CFG_TBSEL +: 3];
   assign mode      = unitControlReg_q[3:0];
   // toggle and the 10xx compare codes share one equality test
   assign match     = ((mode[3:2] == 2'b10) || (mode == CDP_M_TOG))
                      && (timerCountPair_q[tbSel] == compareValueReg_q);
   assign trig      = match && (mode == CDP_M_TRIG);
   assign wrTmrLo   = isWrite(regAddr, REG_TMR_LO, regWr);
   assign wrTmrHi   = isWrite(regAddr, REG_TMR_HI, regWr);
   assign wrCtl     = isWrite(regAddr, REG_UNIT_CTL, regWr);
   assign pwmMode   = (mode[3:2] == 2'b11);
   assign steerMode = pwmMode && (unitControlReg_q[7:6] == 2'b00);
   assign halfBridge = pwmMode && (unitControlReg_q[7:6] == 2'b10);
   assign pwmRaw    = (pwmPhase_q < duty_q);

   // shutdown pin crosses in through two flops
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shdnMeta_q <= 1'b0;
         shdnSync_q <= 1'b0;
      end
      else
      begin
         shdnMeta_q <= shutdownPin;
         shdnSync_q <= shdnMeta_q;
      end
   end

   // ------------------------------------------------------------
   // timers and compare
   // ------------------------------------------------------------
   always_comb
   begin
      timerCountPair_d  = timerCountPair_q;
      timerOvfFlag_d    = timerOvfFlag_q;
      compareIrqFlag_d  = compareIrqFlag_q;
      compareOut_d      = compareOut_q;
      for (int i = 0; i < 8; i++)
      begin
         timerCountPair_d[i] = timerCountPair_q[i] + 16'h0001;
      end
      // overflow flag: software clears by writing 0, wrap wins
      if (isWrite(regAddr, REG_STATUS, regWr) && !regWrData[STS_TOVF])
         timerOvfFlag_d = 1'b0;
      if (timerCountPair_q[tbSel] == TMR_MAX)
         timerOvfFlag_d = 1'b1;
      if (trig)
         timerCountPair_d[tbSel] = TMR_ZERO;
      if (wrTmrLo)
         timerCountPair_d[tbSel][7:0] = regWrData;
      if (wrTmrHi)
         timerCountPair_d[tbSel][15:8] = regWrData;
      if (isWrite(regAddr, REG_STATUS, regWr) && !regWrData[STS_CMPF])
         compareIrqFlag_d = 1'b0;
      if (match)
      begin
         compareIrqFlag_d = 1'b1;
         case (mode)
            CDP_M_SETHI: compareOut_d = 1'b1;
            CDP_M_SETLO: compareOut_d = 1'b0;
            CDP_M_TOG:   compareOut_d = !compareOut_q;
            default:     compareOut_d = compareOut_q;
         endcase
      end
      if (wrCtl && regWrData == RST_BYTE)
         compareOut_d = 1'b0;
   end

   // ------------------------------------------------------------
   // register writes, status, pwm, dead band, steering
   // ------------------------------------------------------------
   always_comb
   begin
      compareValueReg_d    = compareValueReg_q;
      unitControlReg_d     = unitControlReg_q;
      deadBandCtl_d        = deadBandCtl_q;
      steeringControlReg_d = steeringControlReg_q;
      config_d             = config_q;
      duty_d               = duty_q;
      shutdownStatus_d     = shutdownStatus_q;
      pwmPhase_d           = pwmPhase_q + 8'h01;
      if (isWrite(regAddr, REG_CMP_LO, regWr)) compareValueReg_d[7:0] = regWrData;
      if (isWrite(regAddr, REG_CMP_HI, regWr)) compareValueReg_d[15:8] = regWrData;
      if (wrCtl) unitControlReg_d = regWrData;
      if (isWrite(regAddr, REG_DEL, regWr)) deadBandCtl_d = regWrData;
      if (isWrite(regAddr, REG_STEER, regWr)) steeringControlReg_d = regWrData[3:0];
      if (isWrite(regAddr, REG_CONFIG, regWr)) config_d = regWrData;
      if (isWrite(regAddr, REG_DUTY, regWr)) duty_d = regWrData;
      // shutdown status: software clear whenever the synced pin is low, with or without restart
      if (isWrite(regAddr, REG_STATUS, regWr) && !regWrData[STS_SHDN] && !shdnSync_q)
         shutdownStatus_d = 1'b0;
      if (deadBandCtl_q[DEL_RSEN] && !shdnSync_q)
         shutdownStatus_d = 1'b0;
      if (shdnSync_q)
         shutdownStatus_d = 1'b1;
   end

   // dead band counters: count while the wanted level is active
   always_comb
   begin
      dbCntA_d = pwmRaw ? ((dbCntA_q == deadBandCtl_q[6:0]) ? dbCntA_q : dbCntA_q + 7'h01)
                        : 7'h00;
      dbCntB_d = !pwmRaw ? ((dbCntB_q == deadBandCtl_q[6:0]) ? dbCntB_q : dbCntB_q + 7'h01)
                         : 7'h00;
      // active edge waits the count; inactive edge is immediate
      rawPins = {4{pwmRaw}};
      // the held count is cycles already waited, so a count of n holds n cycles
      if (halfBridge)
         rawPins = {2'b00, !pwmRaw && (dbCntB_q == deadBandCtl_q[6:0]),
                    pwmRaw && (dbCntA_q == deadBandCtl_q[6:0])};
      pins_d = 4'h0;
      if (steerMode)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (steeringControlReg_q[i])
               pins_d[i] = shutdownStatus_q ? 1'b0
                         : (pwmRaw ^ (i < 2 ? mode[1] : mode[0]));
         end
      end
      else if (halfBridge && !shutdownStatus_q)
         pins_d = rawPins;
   end

   // ------------------------------------------------------------
   // event outputs and read mux
   // ------------------------------------------------------------
   always_comb
   begin
      irq_d = timerOvfFlag_q && config_q[CFG_TOIE];
      adc_d = trig && config_q[CFG_UNIT2] && config_q[CFG_ADON];
      rdData_d = 8'h00;
      if (regRd)
      begin
         case (regAddr)
            REG_TMR_LO:   rdData_d = timerCountPair_q[tbSel][7:0];
            REG_TMR_HI:   rdData_d = timerCountPair_q[tbSel][15:8];
            REG_CMP_LO:   rdData_d = compareValueReg_q[7:0];
            REG_CMP_HI:   rdData_d = compareValueReg_q[15:8];
            REG_UNIT_CTL: rdData_d = unitControlReg_q;
            REG_DEL:      rdData_d = deadBandCtl_q;
            REG_STEER:    rdData_d = {4'h0, steeringControlReg_q};
            REG_STATUS:   rdData_d = {5'h00, shutdownStatus_q, compareIrqFlag_q, timerOvfFlag_q};
            REG_CONFIG:   rdData_d = config_q;
            REG_DUTY:     rdData_d = duty_q;
            default:      rdData_d = 8'h00;
         endcase
      end
   end

   // all registered state except the shutdown synchroniser
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 8; i++) timerCountPair_q[i] <= TMR_ZERO;
         compareValueReg_q    <= TMR_ZERO;
         unitControlReg_q     <= RST_BYTE;
         deadBandCtl_q        <= RST_BYTE;
         steeringControlReg_q <= 4'h0;
         config_q             <= RST_BYTE;
         duty_q               <= RST_BYTE;
         pwmPhase_q           <= RST_BYTE;
         timerOvfFlag_q       <= 1'b0;
         compareIrqFlag_q     <= 1'b0;
         shutdownStatus_q     <= 1'b0;
         compareOut_q         <= 1'b0;
         dbCntA_q             <= 7'h00;
         dbCntB_q             <= 7'h00;
         pins_q               <= 4'h0;
         rdData_q             <= RST_BYTE;
         irq_q                <= 1'b0;
         adc_q                <= 1'b0;
      end
      else
      begin
         timerCountPair_q     <= timerCountPair_d;
         compareValueReg_q    <= compareValueReg_d;
         unitControlReg_q     <= unitControlReg_d;
         deadBandCtl_q        <= deadBandCtl_d;
         steeringControlReg_q <= steeringControlReg_d;
         config_q             <= config_d;
         duty_q               <= duty_d;
         pwmPhase_q           <= pwmPhase_d;
         timerOvfFlag_q       <= timerOvfFlag_d;
         compareIrqFlag_q     <= compareIrqFlag_d;
         shutdownStatus_q     <= shutdownStatus_d;
         compareOut_q         <= compareOut_d;
         dbCntA_q             <= dbCntA_d;
         dbCntB_q             <= dbCntB_d;
         pins_q               <= pins_d;
         rdData_q             <= rdData_d;
         irq_q                <= irq_d;
         adc_q                <= adc_d;
      end
   end

   assign regRdData        = rdData_q;
   assign compareOut       = compareOut_q;
   assign pwmOutputPins    = pins_q;
   assign timerOverflowIrq = irq_q;
   assign adcStart         = adc_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_trigHit;
      trig && !wrTmrLo && !wrTmrHi;
   endsequence

   a_irq_gated: assert property (@(posedge clock) disable iff (!rst_n)
      !config_q[CFG_TOIE] |=> !timerOverflowIrq) else $error("irq while disabled");
   a_trig_reset: assert property (@(posedge clock) disable iff (!rst_n)
      s_trigHit |=> timerCountPair_q[$past(tbSel)] == TMR_ZERO) else $error("no trigger reset");
   a_adc_start: assert property (@(posedge clock) disable iff (!rst_n)
      adcStart |-> $past(config_q[CFG_ADON]) && $past(trig)) else $error("bad adc start");
   a_cmp_flag: assert property (@(posedge clock) disable iff (!rst_n)
      match |=> compareIrqFlag_q) else $error("compare flag missed");
   a_sw_irq: assert property (@(posedge clock) disable iff (!rst_n)
      (match && mode == CDP_M_SWIRQ && !wrCtl) |=> $stable(compareOut)) else $error("pin moved");
   a_ctl_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (wrCtl && regWrData == RST_BYTE) |=> !compareOut) else $error("output not cleared");
   a_sethi_act: assert property (@(posedge clock) disable iff (!rst_n)
      (match && mode == CDP_M_SETHI && !wrCtl) |=> compareOut) else $error("not driven high");
   a_steer_off: assert property (@(posedge clock) disable iff (!rst_n)
      (steerMode && !steeringControlReg_q[0]) |=> !pwmOutputPins[0]) else $error("unsteered pin active");
endmodule : cdp_unit

// >>> tb/cdp_switch_model.sv
// cdp_switch_model: power switch stage hanging on the pwm and compare pins
// assumes the bench commands fault trips and says when the pins form one leg
`timescale 1ns/100ps
module cdp_switch_model
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // bench side
   input  wire logic       tripReq,
   input  wire logic       halfBridge,
   output int              overlapCnt,
   // pins
   input  wire logic [3:0] pwmOutputPins,
   input  wire logic       compareOut,
   output logic            shutdownPin
);
   // ------------------------------------------------------------
   // fault sense and shoot-through watch
   // ------------------------------------------------------------
   // pins are taken as driven outputs, never floating
   always @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         shutdownPin <= 1'b0;
         overlapCnt  <= 0;
      end
      else
      begin
         shutdownPin <= tripReq;
         // both switches of one leg on at once would short the supply
         if (halfBridge && pwmOutputPins[0] && pwmOutputPins[1])
            overlapCnt <= overlapCnt + 1;
      end
endmodule : cdp_switch_model

// >>> tb/tb.sv
// tb: self-checking bench for cdp_unit beside a switch-stage model
// assumes the register map and mode codes of cdp_pkg
`timescale 1ns/100ps
module tb;
   import cdp_pkg::*;
   logic       clock      = 1'b0;
   logic       rst_n      = 1'b0;
   logic [3:0] regAddr    = 4'h0;
   logic [7:0] regWrData  = 8'h00;
   logic       regWr      = 1'b0;
   logic       regRd      = 1'b0;
   logic       tripReq    = 1'b0;
   logic       halfBridge = 1'b0;
   logic [7:0] regRdData, rv, got;
   logic [3:0] pwmOutputPins;
   logic       shutdownPin, compareOut, timerOverflowIrq, adcStart, expOut;
   int         mismatches = 0;
   int         checks     = 0;
   int         seed       = 39539;
   int         adcCnt     = 0;
   int         overlapCnt;
   int         hiCnt[4]   = '{0, 0, 0, 0};
   cdp_mode_t  modeQ[$]   = '{CDP_M_SETHI, CDP_M_TOG, CDP_M_SWIRQ, CDP_M_SETLO, CDP_M_TOG, CDP_M_TRIG};

   always #2 clock = ~clock;

   cdp_unit DUT (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .shutdownPin(shutdownPin), .compareOut(compareOut),
      .pwmOutputPins(pwmOutputPins), .timerOverflowIrq(timerOverflowIrq), .adcStart(adcStart));
   cdp_switch_model sw (.clock(clock), .rst_n(rst_n), .tripReq(tripReq), .halfBridge(halfBridge),
      .overlapCnt(overlapCnt), .pwmOutputPins(pwmOutputPins), .compareOut(compareOut),
      .shutdownPin(shutdownPin));

   // ------------------------------------------------------------
   // tallies and bus tasks
   // ------------------------------------------------------------
   // running sums let a test take differences over exact spans
   always @(posedge clock)
   begin
      adcCnt <= adcCnt + int'(adcStart);
      for (int i = 0; i < 4; i++)
         hiCnt[i] <= hiCnt[i] + int'(pwmOutputPins[i]);
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clock);
      regWr     <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd   <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   // settle for a while, then tally two whole 256-cycle periods
   task automatic pwmRun(input logic [7:0] ctl, input logic [7:0] del, input logic [3:0] st,
                         input logic [7:0] duty, output int n[4]);
      wr(REG_DUTY, duty);
      wr(REG_DEL, del);
      wr(REG_STEER, {4'h0, st});
      wr(REG_UNIT_CTL, ctl);
      repeat (300) @(posedge clock);
      #1 n = hiCnt;
      repeat (512) @(posedge clock);
      #1 for (int i = 0; i < 4; i++) n[i] = hiCnt[i] - n[i];
   endtask : pwmRun

   task automatic results();
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // hang guard, far beyond the few thousand cycles the run needs
   initial
   begin
      repeat (40000) @(posedge clock);
      mismatches++;
      results();
   end

   initial
   begin
      int n[4];
      int dc;
      int duty;
      logic [3:0] st;
      logic [2:0] sel;
      logic [7:0] hiT;
      logic ad, u2;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      // reset values, the unmapped index included
      for (int a = 2; a < 11; a++)
      begin
         rd(4'(a), rv);
         chk("resetValue", rv, RST_BYTE);
      end
      rv = 8'($random(seed));
      wr(REG_DEL, rv);
      rd(REG_DEL, got);
      chk("delayReg", got, rv);
      wr(4'hf, 8'h5a);
      rd(4'hf, got);
      chk("unmapped", got, 8'h00);
      // compare modes against the behavioural pin model
      expOut = 1'b0;
      foreach (modeQ[k])
      begin
         sel = 3'($random(seed));
         {ad, u2} = 2'($random(seed));
         hiT = 8'h10 | 8'($random(seed) & 32'h7f);
         wr(REG_CONFIG, {2'b00, u2, ad, sel, 1'b0});
         wr(REG_CMP_LO, 8'h30);
         wr(REG_CMP_HI, hiT);
         // synchronous timer writes keep compare and reset reliable
         wr(REG_TMR_LO, 8'h00);
         wr(REG_TMR_HI, hiT);
         wr(REG_STATUS, 8'h00);
         n[0] = adcCnt;
         wr(REG_UNIT_CTL, {4'h0, modeQ[k]});
         repeat (60) @(posedge clock);
         case (modeQ[k])
            CDP_M_SETHI: expOut = 1'b1;
            CDP_M_SETLO: expOut = 1'b0;
            CDP_M_TOG:   expOut = ~expOut;
            default:     expOut = expOut;
         endcase
         #1 chk("compareOut", 16'(compareOut), 16'(expOut));
         rd(REG_STATUS, rv);
         chk("status", rv, 8'h02);
         rd(REG_TMR_HI, rv);
         chk("timerHi", rv, (modeQ[k] == CDP_M_TRIG) ? 8'h00 : hiT);
         chk("adcStart", 16'(adcCnt - n[0]), 16'((modeQ[k] == CDP_M_TRIG && ad && u2) ? 1 : 0));
      end
      wr(REG_UNIT_CTL, 8'h00);
      #1 chk("ctlCleared", 16'(compareOut), 16'h0000);
      // overflow flag and its enable
      wr(REG_CONFIG, 8'h00);
      wr(REG_TMR_LO, 8'h00);
      wr(REG_TMR_HI, TMR_MAX[15:8]);
      repeat (300) @(posedge clock);
      rd(REG_STATUS, rv);
      chk("ovfFlag", 16'(rv[STS_TOVF]), 16'h0001);
      chk("irqMasked", 16'(timerOverflowIrq), 16'h0000);
      wr(REG_CONFIG, 8'h01);
      repeat (2) @(posedge clock);
      #1 chk("irqOn", 16'(timerOverflowIrq), 16'h0001);
      wr(REG_STATUS, 8'h00);
      repeat (2) @(posedge clock);
      #1 chk("irqOff", 16'(timerOverflowIrq), 16'h0000);
      // half bridge: only the rising edges lose the dead band
      halfBridge <= 1'b1;
      for (int j = 0; j < 2; j++)
      begin
         dc = j * (1 + ($random(seed) & 31));
         duty = 64 + ($random(seed) & 127);
         pwmRun(8'h8c, 8'(dc), 4'h0, 8'(duty), n);
         chk("bridgeA", 16'(n[0]), 16'(2 * (duty - dc)));
         chk("bridgeB", 16'(n[1]), 16'(2 * (256 - duty - dc)));
      end
      chk("overlap", 16'(overlapCnt), 16'h0000);
      halfBridge <= 1'b0;
      // steering with every polarity code
      for (int p = 0; p < 4; p++)
      begin
         st = 4'($random(seed)) | 4'h1;
         duty = 64 + ($random(seed) & 127);
         pwmRun({4'h0, 2'b11, 2'(p)}, 8'h00, st, 8'(duty), n);
         for (int i = 0; i < 4; i++)
            if (st[i])
               chk("steerOn", 16'(n[i]), 16'(((i < 2) ? p[1] : p[0]) ? 512 - 2 * duty : 2 * duty));
            else
               chk("steerOff", 16'(n[i]), 16'h0000);
      end
      // shutdown without and with automatic restart
      for (int r = 0; r < 2; r++)
      begin
         wr(REG_DEL, {r[0], 7'h00});
         #1 rv = {4'h0, pwmOutputPins & ~st};
         @(posedge clock);
         tripReq <= 1'b1;
         repeat (20) @(posedge clock);
         tripReq <= 1'b0;
         #1 chk("offPins", 16'(pwmOutputPins & ~st), 16'(rv[3:0]));
         chk("shdnPins", 16'(pwmOutputPins & st), 16'h0000);
         repeat (20) @(posedge clock);
         rd(REG_STATUS, got);
         chk("shdnHold", 16'(got[STS_SHDN]), 16'(!r[0]));
         wr(REG_STATUS, 8'h00);
         repeat (4) @(posedge clock);
         rd(REG_STATUS, got);
         chk("shdnClear", 16'(got[STS_SHDN]), 16'h0000);
      end
      results();
   end
endmodule : tb
